/* File: logic/rtcd_pkg.sv */
// Package for the radio test command decoder: field layout, codes, widths.
// Assumes a byte-wide serial front end outside the block.
package rtcd_pkg;
  localparam int CMD_W = 2;
  localparam int CTL_W = 6;
  localparam int PAR_W = 6;
  localparam int TRL_W = 2;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int SEL_W = 4;
  // Field positions within the command word
  localparam int CMD_LSB = 14;
  localparam int CTL_LSB = 8;
  localparam int PAR_LSB = 2;
  localparam int TRL_LSB = 0;
  // Command codes
  localparam logic [1:0] CMD_SETUP = 2'h0;
  localparam logic [1:0] CMD_RX = 2'h1;
  localparam logic [1:0] CMD_TX = 2'h2;
  localparam logic [1:0] CMD_END = 2'h3;
  localparam logic [5:0] CTL_RESET = 6'h00;
  localparam logic [5:0] CTL_PHY = 6'h02;
  localparam logic [5:0] CTL_TXPWR = 6'h06;
  localparam logic [5:0] CTL_PKTOVR = 6'h07;
  localparam logic [5:0] OVR_NONE = 6'h00;
  localparam logic [5:0] OVR_CARRIER = 6'h01;
  localparam logic [5:0] TXPWR_MAX = 6'h11;
  localparam logic [5:0] TXPWR_RST = 6'h00;
  // Serial personality and pin settings
  localparam logic [3:0] SEL_DTM = 4'h0;
  localparam logic [3:0] SEL_BYPASS = 4'h5;
  localparam logic [3:0] USB_PIN_DIRECT = 4'h7;
  localparam logic [3:0] VBUS_DETECT = 4'h5;
  localparam logic [7:0] ESC_CHAR = 8'h2b;
  localparam int ESC_COUNT = 3;
  localparam logic [15:0] RSP_OK = 16'h0000;
  localparam logic [15:0] RSP_ERR = 16'h0001;
  localparam logic [15:0] RSP_END = 16'h8000;
  // Status value position in an answer word
  localparam int RSP_LSB = 1;
  localparam logic [5:0] PKT_CARRIER_CODE = 6'h3f;

  typedef struct packed {
    logic [CMD_W-1:0] cmd;
    logic [CTL_W-1:0] ctl;
    logic [PAR_W-1:0] par;
    logic [TRL_W-1:0] trl;
  } rtcd_word_t;

  typedef struct packed {
    logic valid;
    logic [BYTE_W-1:0] data;
  } rtcd_byte_t;
endpackage

/* File: logic/rtcd_sync.sv */
// Two-flop synchroniser for pin-level inputs, one bit per lane.
// Assumes inputs may change at any time relative to i_clk.
`timescale 1ns/1ps
module rtcd_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;
endmodule

/* File: logic/rtcd_decoder.sv */
// Test command decoder: two-byte command words in, two-byte responses out.
// Assumes a UART byte front end on i_clk; config pins are asynchronous.
`timescale 1ns/1ps
// Function
// - Each command is exactly two bytes making one 16-bit word.
// - Each accepted command is answered with exactly two bytes.
// - Words in both directions travel most significant byte first.
// - Setup control 6 sets transmit power in whole dBm from 0 to 17.
// - The power answer reports the applied power, clamped to the radio limit.
// - Setup control 7 sets packet override: 0 none, 1 unmodulated carrier.
// - An active override wins over the packet type of later test commands.
// - Three escape characters in a row enter command mode.
// - Personality 5 with Bluetooth enabled flags primary UART bypass on o_bypass_active; no traffic is passed through.
// - Personality 0 decodes primary UART traffic as test words.
// - USB direct is active only with pin setting 7 and bus detect 5.
// - Radio-off setting 1 keeps the modem off during testing, 0 on.
// - An update request is refused at once while sleeping or shutting down.
module rtcd_decoder #(
  parameter logic [5:0] RADIO_MAX_DBM = 6'h11
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Received bytes
  input wire rtcd_pkg::rtcd_byte_t i_rx,
  // Transmit bytes
  input wire logic i_tx_ready,
  output rtcd_pkg::rtcd_byte_t o_tx,
  // Configuration pins
  input wire logic [3:0] i_serial_personality_select,
  input wire logic [3:0] i_usb_direct_pin_config,
  input wire logic [3:0] i_vbus_detect_select,
  input wire logic i_radio_off_select,
  input wire logic i_bluetooth_enable,
  // Update request
  input wire logic i_update_req,
  input wire logic i_sleep_pending,
  input wire logic i_shutdown_pending,
  output logic o_update_accept,
  output logic o_update_error,
  // Status and radio controls
  output logic o_command_mode,
  output logic o_bypass_active,
  output logic o_usb_direct_active,
  output logic o_modem_power,
  output logic [5:0] o_tx_power,
  output logic o_carrier_override,
  output logic o_test_start,
  output logic [5:0] o_test_pkt_type,
  output logic o_test_end
);
  localparam int NSYNC = 15;

  typedef enum logic [1:0] {ST_HI, ST_LO, ST_RSP_HI, ST_RSP_LO} rtcd_st_t;

  logic [NSYNC-1:0] pins_s;
  logic [3:0] pers_s;
  logic [3:0] usbp_s;
  logic [3:0] vbus_s;
  logic roff_s;
  logic bten_s;
  logic slp_s;
  logic shd_s;

  rtcd_sync #(.WIDTH(NSYNC)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_serial_personality_select, i_usb_direct_pin_config,
              i_vbus_detect_select, i_radio_off_select, i_bluetooth_enable,
              i_sleep_pending}),
    .o_sync(pins_s)
  );
  assign {pers_s, usbp_s, vbus_s, roff_s, bten_s, slp_s} = pins_s;
  assign shd_s = i_shutdown_pending;

  rtcd_st_t st_q, st_d;
  logic [7:0] hi_q, hi_d;
  logic [15:0] rsp_q, rsp_d;
  logic [1:0] esc_q, esc_d;
  logic cmdm_q, cmdm_d;
  logic [5:0] pwr_q, pwr_d;
  logic ovr_q, ovr_d;
  rtcd_pkg::rtcd_byte_t tx_q, tx_d;
  logic byp_q, byp_d;
  logic usb_q, usb_d;
  logic modem_q, modem_d;
  logic start_q, start_d;
  logic [5:0] ptype_q, ptype_d;
  logic end_q, end_d;
  logic upa_q, upa_d;
  logic upe_q, upe_d;
  rtcd_pkg::rtcd_word_t w;

  function automatic logic [5:0] clamp_pwr(input logic [5:0] req);
    logic [5:0] lim;
    lim = (RADIO_MAX_DBM < rtcd_pkg::TXPWR_MAX) ? RADIO_MAX_DBM
                                                : rtcd_pkg::TXPWR_MAX;
    clamp_pwr = (req > lim) ? lim : req;
  endfunction

  always_comb begin
    st_d = st_q;
    hi_d = hi_q;
    rsp_d = rsp_q;
    esc_d = esc_q;
    cmdm_d = cmdm_q;
    pwr_d = pwr_q;
    ovr_d = ovr_q;
    tx_d = tx_q;
    start_d = 1'b0;
    end_d = 1'b0;
    ptype_d = ptype_q;
    w = {hi_q, i_rx.data};
    // Escape counting on any received byte
    if (i_rx.valid) begin
      if (i_rx.data == rtcd_pkg::ESC_CHAR) begin
        if (esc_q == 2'(rtcd_pkg::ESC_COUNT - 1)) begin
          cmdm_d = 1'b1;
          esc_d = 2'h0;
        end else begin
          esc_d = esc_q + 2'h1;
        end
      end else begin
        esc_d = 2'h0;
      end
    end
    if (tx_q.valid && i_tx_ready) begin
      tx_d.valid = 1'b0;
    end
    unique case (st_q)
      ST_HI: begin
        if (i_rx.valid && !cmdm_d && pers_s == rtcd_pkg::SEL_DTM) begin
          hi_d = i_rx.data;
          st_d = ST_LO;
        end
      end
      ST_LO: begin
        if (i_rx.valid) begin
          st_d = ST_RSP_HI;
          rsp_d = rtcd_pkg::RSP_ERR;
          unique case (w.cmd)
            rtcd_pkg::CMD_SETUP: begin
              unique case (w.ctl)
                rtcd_pkg::CTL_TXPWR: begin
                  pwr_d = clamp_pwr(w.par);
                  rsp_d = 16'(clamp_pwr(w.par)) << rtcd_pkg::RSP_LSB;
                end
                rtcd_pkg::CTL_PKTOVR: begin
                  if (w.par == rtcd_pkg::OVR_NONE ||
                      w.par == rtcd_pkg::OVR_CARRIER) begin
                    ovr_d = (w.par == rtcd_pkg::OVR_CARRIER);
                    rsp_d = rtcd_pkg::RSP_OK;
                  end
                end
                rtcd_pkg::CTL_RESET, rtcd_pkg::CTL_PHY: begin
                  rsp_d = rtcd_pkg::RSP_OK;
                  if (w.ctl == rtcd_pkg::CTL_RESET) begin
                    ovr_d = 1'b0;
                  end
                end
                default: rsp_d = rtcd_pkg::RSP_ERR;
              endcase
            end
            rtcd_pkg::CMD_RX, rtcd_pkg::CMD_TX: begin
              start_d = 1'b1;
              ptype_d = ovr_q ? rtcd_pkg::PKT_CARRIER_CODE : w.par;
              rsp_d = rtcd_pkg::RSP_OK;
            end
            default: begin
              end_d = 1'b1;
              rsp_d = rtcd_pkg::RSP_END;
            end
          endcase
        end
      end
      ST_RSP_HI: begin
        if (!tx_d.valid) begin
          tx_d = '{valid: 1'b1, data: rsp_q[15:8]};
          st_d = ST_RSP_LO;
        end
      end
      ST_RSP_LO: begin
        if (!tx_d.valid) begin
          tx_d = '{valid: 1'b1, data: rsp_q[7:0]};
          st_d = ST_HI;
        end
      end
    endcase
    byp_d = bten_s && (pers_s == rtcd_pkg::SEL_BYPASS);
    usb_d = (usbp_s == rtcd_pkg::USB_PIN_DIRECT) &&
            (vbus_s == rtcd_pkg::VBUS_DETECT);
    modem_d = !roff_s;
    upe_d = i_update_req && (slp_s || shd_s);
    upa_d = i_update_req && !(slp_s || shd_s);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= ST_HI;
      hi_q <= 8'h00;
      rsp_q <= 16'h0000;
      esc_q <= 2'h0;
      cmdm_q <= 1'b0;
      pwr_q <= rtcd_pkg::TXPWR_RST;
      ovr_q <= 1'b0;
      tx_q <= '0;
      byp_q <= 1'b0;
      usb_q <= 1'b0;
      modem_q <= 1'b0;
      start_q <= 1'b0;
      ptype_q <= 6'h00;
      end_q <= 1'b0;
      upa_q <= 1'b0;
      upe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      hi_q <= hi_d;
      rsp_q <= rsp_d;
      esc_q <= esc_d;
      cmdm_q <= cmdm_d;
      pwr_q <= pwr_d;
      ovr_q <= ovr_d;
      tx_q <= tx_d;
      byp_q <= byp_d;
      usb_q <= usb_d;
      modem_q <= modem_d;
      start_q <= start_d;
      ptype_q <= ptype_d;
      end_q <= end_d;
      upa_q <= upa_d;
      upe_q <= upe_d;
    end
  end

  assign o_tx = tx_q;
  assign o_command_mode = cmdm_q;
  assign o_bypass_active = byp_q;
  assign o_usb_direct_active = usb_q;
  assign o_modem_power = modem_q;
  assign o_tx_power = pwr_q;
  assign o_carrier_override = ovr_q;
  assign o_test_start = start_q;
  assign o_test_pkt_type = ptype_q;
  assign o_test_end = end_q;
  assign o_update_accept = upa_q;
  assign o_update_error = upe_q;
endmodule

/* File: test/rtcd_decoder_props.sv */
// Checker for the test command decoder, ports only.
// Assumes binding to rtcd_decoder; one clock domain.
`timescale 1ns/1ps
module rtcd_decoder_props #(
  parameter logic [5:0] RADIO_MAX_DBM = 6'h11
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tx_ready,
  input wire rtcd_pkg::rtcd_byte_t o_tx,
  input wire logic [3:0] i_serial_personality_select,
  input wire logic [3:0] i_usb_direct_pin_config,
  input wire logic [3:0] i_vbus_detect_select,
  input wire logic i_radio_off_select,
  input wire logic i_bluetooth_enable,
  input wire logic i_update_req,
  input wire logic i_shutdown_pending,
  input wire logic o_update_accept,
  input wire logic o_update_error,
  input wire logic o_command_mode,
  input wire logic o_bypass_active,
  input wire logic o_usb_direct_active,
  input wire logic o_modem_power,
  input wire logic [5:0] o_tx_power,
  input wire logic o_carrier_override,
  input wire logic o_test_start,
  input wire logic [5:0] o_test_pkt_type,
  input wire logic o_test_end
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_tx_hold: assert property (o_tx.valid && !i_tx_ready |=>
    o_tx.valid && $stable(o_tx.data)) else $error("tx byte dropped");
  a_end_answer: assert property (o_test_end |-> ##[1:2]
    (o_tx.valid && o_tx.data == 8'h80)) else $error("end answer");
  a_power_limit: assert property (o_tx_power <= RADIO_MAX_DBM)
    else $error("power above limit");
  a_carrier_wins: assert property (o_test_start && o_carrier_override
    |-> ##[0:1] o_test_pkt_type == rtcd_pkg::PKT_CARRIER_CODE)
    else $error("override lost");
  a_update_refuse: assert property (i_update_req && i_shutdown_pending
    |=> o_update_error && !o_update_accept) else $error("update taken");
  a_mode_sticky: assert property (o_command_mode |=> o_command_mode)
    else $error("command mode lost");
  a_bypass_sel: assert property ((i_bluetooth_enable &&
    i_serial_personality_select == rtcd_pkg::SEL_BYPASS)[*5]
    |-> o_bypass_active) else $error("bypass off");
  a_usb_direct: assert property ($stable({i_usb_direct_pin_config,
    i_vbus_detect_select})[*4] |-> o_usb_direct_active ==
    (i_usb_direct_pin_config == rtcd_pkg::USB_PIN_DIRECT &&
    i_vbus_detect_select == rtcd_pkg::VBUS_DETECT))
    else $error("usb direct");
  a_modem_off: assert property (i_radio_off_select[*5]
    |-> !o_modem_power) else $error("modem on");
endmodule

bind rtcd_decoder rtcd_decoder_props #(.RADIO_MAX_DBM(RADIO_MAX_DBM)) i_props (
  .i_clk, .i_rst_n, .i_tx_ready, .o_tx, .i_serial_personality_select,
  .i_usb_direct_pin_config, .i_vbus_detect_select, .i_radio_off_select,
  .i_bluetooth_enable, .i_update_req, .i_shutdown_pending, .o_update_accept,
  .o_update_error, .o_command_mode, .o_bypass_active, .o_usb_direct_active,
  .o_modem_power, .o_tx_power, .o_carrier_override, .o_test_start,
  .o_test_pkt_type, .o_test_end);

/* File: test/rtcd_host_model.sv */
// Test host model: takes response bytes, prompt or stalling.
// Assumes the decoder's valid/ready byte handshake on i_clk.
`timescale 1ns/1ps
module rtcd_host_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Response bytes
  input wire rtcd_pkg::rtcd_byte_t i_tx,
  input wire logic i_stall,
  output logic o_ready,
  output logic [15:0] o_rsp,
  output logic [7:0] o_count
);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
      o_rsp <= 16'h0000;
      o_count <= 8'h00;
    end else begin
      o_ready <= i_stall ? ~o_ready : 1'b1;
      if (i_tx.valid && o_ready) begin
        o_rsp <= {o_rsp[7:0], i_tx.data};
        o_count <= o_count + 8'h01;
      end
    end
  end
endmodule

/* File: test/rtcd_decoder_tb.sv */
// Self-checking bench for the test command decoder.
// Assumes rtcd_host_model and the bound checker.
`timescale 1ns/1ps
module rtcd_decoder_tb;
  logic i_clk, i_rst_n, i_tx_ready, stall, i_radio_off_select;
  logic i_bluetooth_enable, i_update_req, i_sleep_pending;
  logic i_shutdown_pending, o_update_accept, o_update_error;
  logic o_command_mode, o_bypass_active, o_usb_direct_active;
  logic o_modem_power, o_carrier_override, o_test_start, o_test_end;
  logic [3:0] i_serial_personality_select, i_usb_direct_pin_config;
  logic [3:0] i_vbus_detect_select;
  logic [5:0] o_tx_power, o_test_pkt_type;
  logic [15:0] rsp;
  logic [7:0] cnt;
  rtcd_pkg::rtcd_byte_t i_rx, o_tx;
  int fail_count = 0;
  int total_checks = 0;
  rtcd_decoder #(.RADIO_MAX_DBM(6'h0f)) i_rtcd_decoder (.i_clk, .i_rst_n,
    .i_rx, .i_tx_ready, .o_tx, .i_serial_personality_select,
    .i_usb_direct_pin_config, .i_vbus_detect_select, .i_radio_off_select,
    .i_bluetooth_enable, .i_update_req, .i_sleep_pending,
    .i_shutdown_pending, .o_update_accept, .o_update_error,
    .o_command_mode, .o_bypass_active, .o_usb_direct_active, .o_modem_power,
    .o_tx_power, .o_carrier_override, .o_test_start, .o_test_pkt_type,
    .o_test_end);
  rtcd_host_model i_rtcd_host_model (.i_clk, .i_rst_n, .i_tx(o_tx),
    .i_stall(stall), .o_ready(i_tx_ready), .o_rsp(rsp), .o_count(cnt));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Word out high byte first, trailing field as given; wait for answer
  task automatic xfer(input logic [15:0] w, input logic [15:0] exp);
    int k;
    logic [7:0] c0;
    c0 = cnt;
    i_rx = '{1'b1, w[15:8]};
    tick(1);
    i_rx = '{1'b1, w[7:0]};
    tick(1);
    i_rx.valid = 1'b0;
    k = 0;
    while (cnt !== c0 + 8'h02 && k < 60) begin
      tick(1);
      k++;
    end
    if (cnt !== c0 + 8'h02) begin
      fail_count++;
      complete_run();
    end else begin
      chk(rsp, exp);
    end
  endtask
  task automatic t_power();
    stall = 1'b1;
    xfer(16'h0628, 16'h0014);
    chk({10'h000, o_tx_power}, 16'h000a);
    xfer(16'h0644, 16'h001e);
    chk({10'h000, o_tx_power}, 16'h000f);
    stall = 1'b0;
  endtask
  task automatic t_override();
    xfer(16'h0704, 16'h0000);
    chk({15'h0, o_carrier_override}, 16'h0001);
    xfer(16'h80fc, 16'h0000);
    chk({10'h000, o_test_pkt_type}, 16'h003f);
    xfer(16'hc000, 16'h8000);
    xfer(16'h0708, 16'h0001);
    xfer(16'h0700, 16'h0000);
    xfer(16'h4014, 16'h0000);
    chk({10'h000, o_test_pkt_type}, 16'h0005);
  endtask
  task automatic t_pins();
    i_serial_personality_select = 4'h5;
    i_usb_direct_pin_config = 4'h7;
    i_radio_off_select = 1'b1;
    tick(6);
    chk({13'h0, o_bypass_active, o_usb_direct_active,
      o_modem_power}, 16'h0006);
    i_serial_personality_select = 4'h0;
    i_vbus_detect_select = 4'h0;
    i_radio_off_select = 1'b0;
    tick(6);
    chk({13'h0, o_bypass_active, o_usb_direct_active,
      o_modem_power}, 16'h0001);
  endtask
  task automatic t_update();
    i_update_req = 1'b1;
    tick(1);
    i_update_req = 1'b0;
    chk({14'h0, o_update_accept, o_update_error}, 16'h0001);
    i_shutdown_pending = 1'b0;
    i_update_req = 1'b1;
    tick(1);
    i_update_req = 1'b0;
    chk({14'h0, o_update_accept, o_update_error}, 16'h0002);
    i_sleep_pending = 1'b1;
    tick(4);
    i_update_req = 1'b1;
    tick(1);
    i_update_req = 1'b0;
    chk({14'h0, o_update_accept, o_update_error}, 16'h0001);
  endtask
  task automatic t_escape();
    xfer(16'h0c00, 16'h0001);
    xfer(16'h2b2b, 16'h0001);
    i_rx = '{1'b1, 8'h2b};
    tick(1);
    i_rx.valid = 1'b0;
    tick(4);
    chk({15'h0, o_command_mode}, 16'h0001);
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    {i_rst_n, stall, i_update_req, i_sleep_pending} = 4'h0;
    {i_serial_personality_select, i_usb_direct_pin_config} = 8'h00;
    i_vbus_detect_select = 4'h5;
    {i_radio_off_select, i_bluetooth_enable, i_shutdown_pending} = 3'b011;
    i_rx = '{1'b0, 8'h00};
    tick(3);
    i_rst_n = 1'b1;
    tick(5);
    t_power();
    t_override();
    t_pins();
    t_update();
    t_escape();
    complete_run();
  end
endmodule
